//--- bus_demux_defines.svh
`ifndef BUS_DEMUX_DEFINES_SVH
`define BUS_DEMUX_DEFINES_SVH

// ----------------------------------------
// address map
// ----------------------------------------
`define DRAM_BASE          32'h0080_0000
`define DRAM_TOP           32'h017f_ffff
`define ROM_BASE           32'h1fc0_0000
`define ROM_TOP            32'h1fff_ffff
`define PERIPH_BASE        32'h0070_0000
`define PERIPH_TOP         32'h0078_ffff

// ----------------------------------------
// switch fields
// ----------------------------------------
`define SW_DRAM_ILV_BIT    0
`define SW_DRAM_BIG_BIT    1
`define SW_ROM_ILV_BIT     2
`define SW_ROM_SIZE_LSB    3

// ----------------------------------------
// timing, in clock cycles; timeout and clock period in ns
// ----------------------------------------
`define DRAM_FIRST_CYC     4'h5
`define DRAM_NEXT_ILV_CYC  4'h1
`define DRAM_NEXT_SEQ_CYC  4'h2
`define DRAM_WR_MISS_CYC   4'h4
`define DRAM_WR_PAGE_CYC   4'h3
`define ROM_FIRST_CYC      4'h5
`define ROM_NEXT_CYC       4'h4
`define PERIPH_CYC         4'h8
`define TIMEOUT_NS         640
`define CLK_PERIOD_NS      10
`define TIMEOUT_CYC        ((`TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- bus_demux_pkg.sv
`default_nettype none
package bus_demux_pkg;
  typedef enum logic [1:0] {
    SUB_NONE   = 2'b00,
    SUB_DRAM   = 2'b01,
    SUB_ROM    = 2'b10,
    SUB_PERIPH = 2'b11
  } subsys_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_END  = 2'b10
  } cyc_state_t;

  typedef struct packed {
    logic        ilv;
    logic        bank_hi;
    logic [1:0]  bank;
  } bank_sel_t;

  typedef struct packed {
    logic        oe_a;
    logic        oe_b;
    logic        dir_rd;
  } steer_t;
endpackage : bus_demux_pkg
`default_nettype wire

//--- bus_demux_decode.sv
`include "bus_demux_defines.svh"
`default_nettype none

// Notes on behaviour
// - address captured from muxed bus by a latch opened by the address strobe
// - muxed bus split into one address bus and two data buses
// - dram, rom or both may interleave words across the two data buses
// - each exchanger links one processor port to either data bus
// - steering picks the right bus and never drives two at once
// - controllers ignore transactions decoded for other subsystems
// - addressed controller answers at its own subsystem latency
// - one shared cycle-end closes each transaction for all controllers
// - shared decode, steering, timeout and input synchronisation
// - dram banks from 0x0080_0000, sequential or interleaved even/odd pairs
// - dram up to 16MB as four banks or two interleaved pairs
// - rom up to 4MB as two banks or one interleaved pair
// - dram read 5 first, 1 or 2 adjacent; writes 4 or 3 cycles
// - interleave and size switches sampled only at reset release
module bus_demux_decode
  import bus_demux_pkg::*;
(
  // clock and reset
  input  wire  logic                  clock_in,
  input  wire  logic                  rstn_in,
  // processor side
  input  wire  logic [31:0]           ad_in,
  output logic [31:0]                 ad_out,
  output logic                        ad_oe_out,
  input  wire  logic                  addr_strobe_in,
  input  wire  logic                  rd_req_n_in,
  input  wire  logic                  wr_req_n_in,
  input  wire  logic                  burst_in,
  output logic                        ack_out,
  output logic                        bus_error_out,
  // board switches
  input  wire  logic [4:0]            memory_config_switches,
  // memory side
  output logic [31:0]                 addr_out,
  input  wire  logic [31:0]           data_a_in,
  input  wire  logic [31:0]           data_b_in,
  output logic [31:0]                 data_a_out,
  output logic [31:0]                 data_b_out,
  output bus_demux_pkg::steer_t       steer_out,
  output bus_demux_pkg::subsys_t      subsys_out,
  output bus_demux_pkg::bank_sel_t    bank_out,
  output logic                        cycle_end_out
);
  import bus_demux_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       strobe_s;
  logic       rd_s;
  logic       wr_s;
  logic       strobe_prev_q;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {addr_strobe_in, ~rd_req_n_in, ~wr_req_n_in};
      sync2_q <= sync1_q;
    end
  end
  assign strobe_s = sync2_q[2];
  assign rd_s     = sync2_q[1];
  assign wr_s     = sync2_q[0];

  // ----------------------------------------
  // switches, caught after reset release
  // ----------------------------------------
  logic [4:0] sw_q;
  logic       sw_taken_q;

  // switches are static, so no synchroniser; sampled once only
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sw_q       <= 5'h00;
      sw_taken_q <= 1'b0;
    end else if (!sw_taken_q) begin
      sw_q       <= memory_config_switches;
      sw_taken_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // address latch and decode
  // ----------------------------------------
  cyc_state_t state_q;
  logic [31:0] addr_q;
  logic        start;
  logic        end_now;
  logic        is_rd_q;
  logic        first_q;

  assign start = strobe_s && !strobe_prev_q && (state_q == ST_IDLE);

  // latch loads only while idle; held until cycle end except the +4 step after each burst word
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_q        <= 32'h0;
      strobe_prev_q <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_s;
      if (state_q == ST_IDLE && strobe_s) begin
        addr_q <= ad_in;
      end else if (state_q == ST_WAIT && end_now && burst_in) begin
        addr_q <= addr_q + 32'h4;
      end
    end
  end
  assign addr_out = addr_q;

  function automatic subsys_t decode_sub(input logic [31:0] a);
    if (a >= `DRAM_BASE && a <= `DRAM_TOP) begin
      decode_sub = SUB_DRAM;
    end else if (a >= `ROM_BASE && a <= `ROM_TOP) begin
      decode_sub = SUB_ROM;
    end else if (a >= `PERIPH_BASE && a <= `PERIPH_TOP) begin
      decode_sub = SUB_PERIPH;
    end else begin
      decode_sub = SUB_NONE;
    end
  endfunction : decode_sub

  // dram bank map for 1MB/4MB modules, sequential or interleaved
  function automatic bank_sel_t dram_bank(input logic [31:0] a, input logic [4:0] sw);
    logic [31:0] off;
    bank_sel_t   b;
    off       = a - `DRAM_BASE;
    b.ilv     = sw[`SW_DRAM_ILV_BIT];
    b.bank_hi = b.ilv ? a[2] : 1'b0;
    if (sw[`SW_DRAM_BIG_BIT]) begin
      b.bank = b.ilv ? {off[23], a[2]} : off[23:22];
    end else begin
      b.bank = b.ilv ? {off[21], a[2]} : off[21:20];
    end
    dram_bank = b;
  endfunction : dram_bank

  // rom: bank 1 above half the size, or odd word when interleaved
  function automatic bank_sel_t rom_bank(input logic [31:0] a, input logic [4:0] sw);
    bank_sel_t b;
    b.ilv     = sw[`SW_ROM_ILV_BIT];
    b.bank_hi = b.ilv ? a[2] : 1'b0;
    case (sw[`SW_ROM_SIZE_LSB +: 2])
      2'h0:    b.bank = {1'b0, b.ilv ? a[2] : a[19]};
      2'h1:    b.bank = {1'b0, b.ilv ? a[2] : a[20]};
      default: b.bank = {1'b0, b.ilv ? a[2] : a[21]};
    endcase
    rom_bank = b;
  endfunction : rom_bank

  subsys_t   sub;
  bank_sel_t bank;
  always_comb begin
    sub  = decode_sub(addr_q);
    bank = '0;
    if (sub == SUB_DRAM) begin
      bank = dram_bank(addr_q, sw_q);
    end else if (sub == SUB_ROM) begin
      bank = rom_bank(addr_q, sw_q);
    end
  end
  assign subsys_out = (state_q == ST_IDLE) ? SUB_NONE : sub;
  assign bank_out   = bank;

  // ----------------------------------------
  // subsystem latency and master cycle end
  // ----------------------------------------
  logic [3:0]  wait_q;
  logic [3:0]  lat;
  logic [9:0]  tmo_q;
  logic        same_page_q;
  logic        timed_out;

  always_comb begin
    case (sub)
      SUB_DRAM: begin
        if (is_rd_q) begin
          lat = first_q ? `DRAM_FIRST_CYC :
                (sw_q[`SW_DRAM_ILV_BIT] ? `DRAM_NEXT_ILV_CYC : `DRAM_NEXT_SEQ_CYC);
        end else begin
          lat = same_page_q ? `DRAM_WR_PAGE_CYC : `DRAM_WR_MISS_CYC;
        end
      end
      SUB_ROM:    lat = first_q ? `ROM_FIRST_CYC : `ROM_NEXT_CYC;
      SUB_PERIPH: lat = `PERIPH_CYC;
      default:    lat = 4'h0;
    endcase
  end

  assign timed_out = (tmo_q == 10'(`TIMEOUT_CYC));
  assign end_now   = (state_q == ST_WAIT) &&
                     ((sub != SUB_NONE && wait_q == lat) || timed_out);

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= ST_IDLE;
      wait_q  <= 4'h0;
      tmo_q   <= 10'h0;
      is_rd_q <= 1'b0;
      first_q <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          wait_q  <= 4'h1;
          tmo_q   <= 10'h1;
          first_q <= 1'b1;
          if (start && (rd_s || wr_s)) begin
            is_rd_q <= rd_s;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          tmo_q <= tmo_q + 10'h1;
          if (end_now) begin
            wait_q  <= 4'h1;
            first_q <= 1'b0;
            state_q <= (burst_in && !timed_out) ? ST_WAIT : ST_END;
          end else begin
            wait_q <= wait_q + 4'h1;
          end
        end
        ST_END:  state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // last write page of any subsystem, for dram page-write latency
  logic [31:0] last_wr_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_wr_q   <= 32'h0;
      same_page_q <= 1'b0;
    end else if (start) begin
      same_page_q <= (ad_in[31:11] == last_wr_q[31:11]);
    end else if (end_now && !is_rd_q) begin
      last_wr_q <= addr_q;
    end
  end

  assign cycle_end_out = (state_q == ST_END);
  assign ack_out       = end_now && !timed_out;
  assign bus_error_out = end_now && timed_out;

  // ----------------------------------------
  // data steering
  // ----------------------------------------
  steer_t steer;
  always_comb begin
    steer        = '0;
    steer.dir_rd = is_rd_q;
    if (state_q == ST_WAIT && sub != SUB_NONE) begin
      steer.oe_a = !bank.bank[0] || !bank.ilv;
      steer.oe_b = bank.ilv && bank.bank[0];
    end
  end
  assign steer_out = steer;

  logic [31:0] rd_data_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_q <= 32'h0;
    end else if (steer.oe_b) begin
      rd_data_q <= data_b_in;
    end else begin
      rd_data_q <= data_a_in;
    end
  end
  assign ad_out     = rd_data_q;
  assign ad_oe_out  = is_rd_q && (state_q == ST_WAIT);
  // write data from a flop: data outputs are registered, costs one cycle
  logic [31:0] wr_data_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_data_q <= 32'h0;
    end else begin
      wr_data_q <= ad_in;
    end
  end
  assign data_a_out = wr_data_q;
  assign data_b_out = wr_data_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_steer_one_bus: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !(steer.oe_a && steer.oe_b)) else $error("both data buses enabled");
  a_latch_held: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state_q == ST_WAIT && !end_now) |=> $stable(addr_q)) else $error("latch moved");
  a_end_after_ack: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (end_now && !burst_in) |=> cycle_end_out) else $error("no cycle end");
  a_dram_first_read: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (start && rd_s && decode_sub(ad_in) == SUB_DRAM) |-> ##5 ack_out)
    else $error("dram first read latency");
  a_timeout_bound: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (start && (rd_s || wr_s)) |-> ##[1:70] (ack_out || bus_error_out))
    else $error("transaction never ended");
  a_none_ignored: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state_q == ST_WAIT && sub == SUB_NONE) |-> !ack_out) else $error("ack on unmapped");
  a_switch_frozen: assert property (@(posedge clock_in) disable iff (!rstn_in)
    sw_taken_q |=> $stable(sw_q)) else $error("switches resampled");
  a_ilv_odd_bus_b: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state_q == ST_WAIT && sub == SUB_DRAM && bank.ilv && addr_q[2]) |-> steer.oe_b)
    else $error("odd word not on bus b");
  c_dram_read: cover property (@(posedge clock_in) ack_out && sub == SUB_DRAM && is_rd_q);
  c_rom_ilv: cover property (@(posedge clock_in) ack_out && sub == SUB_ROM && bank.ilv);
  c_timeout: cover property (@(posedge clock_in) bus_error_out);
endmodule : bus_demux_decode
`default_nettype wire

//--- mem_side_model.sv
`default_nettype none
// ----------------------------------------
// memory side of the two data buses
// ----------------------------------------
module mem_side_model
  import bus_demux_pkg::*;
(
  // clock and control from the block
  input  wire logic                   clock_in,
  input  wire logic [31:0]            addr_in,
  input  wire bus_demux_pkg::steer_t  steer_in,
  // data buses back to the block
  output logic [31:0]                 data_a_out,
  output logic [31:0]                 data_b_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] idle_q = 32'h0;
  // released bus churns so a stale value never reads as good
  always_ff @(posedge clock_in) begin
    idle_q <= idle_q + 32'h9e37_79b9;
  end
  // when interleaved, bus a holds even words and bus b odd words; otherwise every word is on bus a
  assign data_a_out = (steer_in.oe_a && steer_in.dir_rd) ? ~addr_in : idle_q;
  assign data_b_out = (steer_in.oe_b && steer_in.dir_rd) ? {addr_in[15:0], addr_in[31:16]}
                                                         : ~idle_q;
endmodule : mem_side_model
`default_nettype wire

//--- tb_bus_demux_decode.sv
`default_nettype none
// ----------------------------------------
// bench for the bus demux and decode
// ----------------------------------------
module tb_bus_demux_decode;
  timeunit 1ns;
  timeprecision 1ps;
  import bus_demux_pkg::*;
  logic        clock_in, rstn_in, strobe, rd_n, wr_n, ad_oe, ack, berr, cyc_end;
  logic        burst;
  logic [31:0] ad_in, ad_out, addr_out, da_in, db_in, da_out, db_out;
  logic [4:0]  sw;
  steer_t      steer;
  subsys_t     subsys;
  bank_sel_t   bank;
  int          fails, checks;

  bus_demux_decode dut (.clock_in(clock_in), .rstn_in(rstn_in), .ad_in(ad_in),
    .ad_out(ad_out), .ad_oe_out(ad_oe), .addr_strobe_in(strobe), .rd_req_n_in(rd_n),
    .wr_req_n_in(wr_n), .burst_in(burst), .ack_out(ack), .bus_error_out(berr),
    .memory_config_switches(sw), .addr_out(addr_out), .data_a_in(da_in),
    .data_b_in(db_in), .data_a_out(da_out), .data_b_out(db_out), .steer_out(steer),
    .subsys_out(subsys), .bank_out(bank), .cycle_end_out(cyc_end));
  mem_side_model model (.clock_in(clock_in), .addr_in(addr_out), .steer_in(steer),
    .data_a_out(da_in), .data_b_out(db_in));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check32

  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // switches change right after reset; only the sampled copy may count
  task automatic do_reset(input logic [4:0] s);
    rstn_in = 1'b0;
    sw = s;
    repeat (4) @(posedge clock_in);
    check32({24'h0, cyc_end, ack, berr, subsys, steer}, 32'h0);
    #1 rstn_in = 1'b1;
    repeat (2) @(posedge clock_in);
    #1 sw = ~s;
  endtask : do_reset

  // one whole transfer; bk is {ilv, bank} expected for dram
  task automatic xfer(input logic [31:0] a, input logic wr, input subsys_t sub,
                      input int lat, input logic err, input logic [2:0] bk);
    int n;
    n = 0;
    ad_in = a;
    strobe = 1'b1;
    rd_n = wr;
    wr_n = ~wr;
    do begin
      @(posedge clock_in);
      #1 n++;
      if (n == 3) ad_in = ~a;
      if (n > 200) begin
        fails++;
        report_and_stop();
      end
    end while (!(ack === 1'b1 || berr === 1'b1));
    check32(n, lat + 2);
    check32({31'h0, berr}, {31'h0, err});
    check32(addr_out, a);
    check32({30'h0, subsys}, {30'h0, sub});
    check32({31'h0, steer.oe_a ^ steer.oe_b}, {31'h0, ~err});
    if (!err) check32({31'h0, ad_oe}, {31'h0, ~wr});
    if (wr) check32(da_out, ~a);
    if (sub == SUB_DRAM) check32({29'h0, bank.ilv, bank.bank}, {29'h0, bk});
    @(posedge clock_in);
    #1 check32({31'h0, cyc_end}, 32'h1);
    if (!wr && !err) check32(ad_out, (bk[2] && a[2]) ? {a[15:0], a[31:16]} : ~a);
    strobe = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (3) @(posedge clock_in);
    #1 $display("done %h", a);
  endtask : xfer

  // two-word interleaved dram read: second word follows in one cycle
  task automatic burst_rd(input logic [31:0] a);
    int          n;
    logic [31:0] nxt;
    n = 0;
    nxt = a + 32'h4;
    ad_in = a;
    strobe = 1'b1;
    rd_n = 1'b0;
    wr_n = 1'b1;
    burst = 1'b1;
    do begin
      @(posedge clock_in);
      #1 n++;
      if (n == 3) ad_in = ~a;
      if (n > 200) begin
        fails++;
        report_and_stop();
      end
    end while (ack !== 1'b1);
    check32(n, 32'd7);
    @(posedge clock_in);
    #1 burst = 1'b0;
    check32({31'h0, ack}, 32'h1);
    check32(addr_out, nxt);
    @(posedge clock_in);
    #1 check32({31'h0, cyc_end}, 32'h1);
    check32(ad_out, {nxt[15:0], nxt[31:16]});
    strobe = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (3) @(posedge clock_in);
    #1 $display("done burst %h", a);
  endtask : burst_rd

  initial begin
    fails = 0;
    checks = 0;
    strobe = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    burst = 1'b0;
    ad_in = 32'h0;
    do_reset(5'h00);
    xfer(32'h0090_0000, 1'b0, SUB_DRAM, 5, 1'b0, 3'h1);
    xfer(32'h0080_0100, 1'b1, SUB_DRAM, 4, 1'b0, 3'h0);
    xfer(32'h0080_0104, 1'b1, SUB_DRAM, 3, 1'b0, 3'h0);
    xfer(32'h1fc0_0000, 1'b0, SUB_ROM, 5, 1'b0, 3'h0);
    xfer(32'h0074_0000, 1'b0, SUB_PERIPH, 8, 1'b0, 3'h0);
    xfer(32'h4000_0000, 1'b0, SUB_NONE, 64, 1'b1, 3'h0);
    do_reset(5'h03);
    xfer(32'h0100_0004, 1'b0, SUB_DRAM, 5, 1'b0, 3'h7);
    xfer(32'h0100_0000, 1'b0, SUB_DRAM, 5, 1'b0, 3'h6);
    burst_rd(32'h0100_0000);
    report_and_stop();
  end
endmodule : tb_bus_demux_decode
`default_nettype wire
